// file: hdl/plb_pkg.sv
// constants, encodings and types shared by the programmable logic block model
// assumes one core clock; all configuration is static while the logic runs
// Function
// - two to eight identical blocks, joined through routing
// - exactly 36 inputs in, all outputs back
// - no local feedback path inside the block
// - 72 literals wired-AND into 83 terms
// - 80 logic terms, three shared control terms
// - shared clock and init terms optionally inverted
// - consecutive groups of five terms per macrocell
// - 16 macrocells fed one-to-one by allocator
// - fast, 20-term and up to 80-term paths
// - logic terms ORed, control terms steered out
// - fixed control role per term position
// - group OR drives fast path and allocator
// - macrocell m takes groups m-1 to m+2
// - wide steering links stage n to n+4
// - four wrapping chains with stride four
// - wide steering source macrocell that forwards its sum gets zero
// - macrocell XOR, flop or latch, dual outputs
// - direct I/O input with optional delay
// - eight-way storage clock selector
// - four-way clock enable selector
// - four block clocks from global clock pins
// - power-up state follows set/reset setting only where block init is enabled, else reset
package plb_pkg;

    // sizes of the block
    localparam int PLB_MIN_BLOCKS    = 2;
    localparam int PLB_MAX_BLOCKS    = 8;
    localparam int NUM_INPUTS        = 36;
    localparam int NUM_LITERALS      = 2 * NUM_INPUTS;
    localparam int NUM_TERMS         = 83;
    localparam int NUM_LOGIC_TERMS   = 80;
    localparam int GROUP_SIZE        = 5;
    localparam int NUM_MACROCELLS    = 16;
    localparam int NUM_GCLK          = 4;
    localparam int NUM_BLOCK_CLOCKS  = 4;
    localparam int CHAIN_STRIDE      = 4;
    localparam int NUM_CHAINS        = 4;
    localparam int CHAIN_STAGES      = NUM_MACROCELLS / CHAIN_STRIDE;
    localparam int SYNC_STAGES       = 2;

    // term positions inside a group
    localparam int TERM_XOR_OFS      = 0;
    localparam int TERM_CLK_OFS      = 1;
    localparam int TERM_INIT_CE_OFS  = 2;
    localparam int TERM_INIT_OFS     = 3;
    localparam int TERM_OE_OFS       = 4;

    // shared control terms
    localparam int SHARED_CLK_TERM   = 80;
    localparam int SHARED_INIT_TERM  = 81;
    localparam int SHARED_OE_TERM    = 82;

    // cluster steering: destination = group + bias - select
    localparam int CLUSTER_DEST_BIAS = 1;
    localparam int GROUP_SEL_W       = 2;
    localparam int CLK_SEL_W         = 3;
    localparam int CE_SEL_W          = 2;
    localparam int GCLK_SEL_W        = 2;

    // reset values
    localparam logic OUT_RST         = 1'h0;
    localparam logic STORE_RST       = 1'h0;
    localparam logic PWRUP_RST       = 1'h1;

    typedef enum logic [CLK_SEL_W-1:0] {
        CLK_BLOCK0     = 3'h0,
        CLK_BLOCK1     = 3'h1,
        CLK_BLOCK2     = 3'h2,
        CLK_BLOCK3     = 3'h3,
        CLK_TERM       = 3'h4,
        CLK_TERM_INV   = 3'h5,
        CLK_SHARED     = 3'h6,
        CLK_GROUND     = 3'h7
    } plb_clk_src_t;

    typedef enum logic [CE_SEL_W-1:0] {
        CE_TERM        = 2'h0,
        CE_TERM_INV    = 2'h1,
        CE_SHARED_CLK  = 2'h2,
        CE_HIGH        = 2'h3
    } plb_ce_src_t;

endpackage : plb_pkg

// file: hdl/plb_logic_block.sv
// one programmable logic block: AND array, allocator, 16 macrocells, clock generator
// assumes routing-pool inputs are on core_clk_i; pins are synchronised here
// configuration ports are loaded before operation and never change while running
module plb_logic_block
    import plb_pkg::*;
#(
    parameter int NUM_BLOCKS  = PLB_MAX_BLOCKS,
    parameter int BLOCK_INDEX = 0
)
(
    input  wire logic                                 core_clk_i,
    input  wire logic                                 rst_i,
    input  wire logic [NUM_INPUTS-1:0]                global_routing_pool_i,
    input  wire logic [NUM_MACROCELLS-1:0]            io_direct_i,
    input  wire logic [NUM_GCLK-1:0]                  global_clock_pin_i,
    input  wire logic [NUM_TERMS*NUM_LITERALS-1:0]    and_conn_cfg_i,
    input  wire logic [NUM_LOGIC_TERMS-1:0]           term_ctl_cfg_i,
    input  wire logic [NUM_MACROCELLS*GROUP_SEL_W-1:0] group_dest_cfg_i,
    input  wire logic [NUM_MACROCELLS-1:0]            wide_steer_cfg_i,
    input  wire logic                                 shared_clk_inv_cfg_i,
    input  wire logic                                 shared_init_inv_cfg_i,
    input  wire logic [NUM_MACROCELLS-1:0]            xor_pol_cfg_i,
    input  wire logic [NUM_MACROCELLS*CLK_SEL_W-1:0]  clk_sel_cfg_i,
    input  wire logic [NUM_MACROCELLS*CE_SEL_W-1:0]   ce_sel_cfg_i,
    input  wire logic [NUM_MACROCELLS-1:0]            init_ce_mode_cfg_i,
    input  wire logic [NUM_MACROCELLS-1:0]            block_init_en_cfg_i,
    input  wire logic [NUM_MACROCELLS-1:0]            init_set_cfg_i,
    input  wire logic [NUM_MACROCELLS-1:0]            latch_mode_cfg_i,
    input  wire logic [NUM_MACROCELLS-1:0]            comb_out_cfg_i,
    input  wire logic [NUM_MACROCELLS-1:0]            io_reg_cfg_i,
    input  wire logic [NUM_MACROCELLS-1:0]            io_delay_cfg_i,
    input  wire logic [NUM_BLOCK_CLOCKS*GCLK_SEL_W-1:0] block_clk_pin_cfg_i,
    input  wire logic [NUM_BLOCK_CLOCKS-1:0]          block_clk_inv_cfg_i,
    output logic      [NUM_MACROCELLS-1:0]            global_routing_pool_o,
    output logic      [NUM_MACROCELLS-1:0]            output_routing_pool_o,
    output logic      [NUM_MACROCELLS-1:0]            fast_path_o,
    output logic      [NUM_MACROCELLS-1:0]            individual_term_output_enable_o,
    output logic                                      shared_term_output_enable_o
);

    // refuse device sizes the family cannot have
    if (NUM_BLOCKS < PLB_MIN_BLOCKS || NUM_BLOCKS > PLB_MAX_BLOCKS)
    begin : g_bad_count
        $error("plb_logic_block: NUM_BLOCKS out of range");
    end

    if (BLOCK_INDEX < 0 || BLOCK_INDEX >= NUM_BLOCKS)
    begin : g_bad_index
        $error("plb_logic_block: BLOCK_INDEX out of range");
    end

    logic [NUM_LITERALS-1:0]     literal;
    logic [NUM_TERMS-1:0]        term;
    logic [NUM_MACROCELLS-1:0]   group_or;
    logic [NUM_MACROCELLS-1:0]   cluster_local;
    logic [NUM_MACROCELLS-1:0]   cluster_sum;
    logic [NUM_MACROCELLS-1:0]   wide_eff;
    logic [NUM_MACROCELLS-1:0]   mc_in;
    logic [NUM_BLOCK_CLOCKS-1:0] block_clock;
    logic                        shared_term_clock;
    logic                        shared_term_initialization;
    logic [NUM_GCLK-1:0]         gclk_s1_q;
    logic [NUM_GCLK-1:0]         gclk_s2_q;
    logic [NUM_MACROCELLS-1:0]   io_s1_q;
    logic [NUM_MACROCELLS-1:0]   io_s2_q;
    logic [NUM_MACROCELLS-1:0]   io_dly_q;
    logic                        pwrup_q;
    logic [NUM_MACROCELLS-1:0]   fast_q;
    logic [NUM_MACROCELLS-1:0]   oe_q;
    logic                        shared_oe_q;

    // pin synchronisers; stage one is read only by stage two
    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            gclk_s1_q <= '0;
            gclk_s2_q <= '0;
            io_s1_q   <= '0;
            io_s2_q   <= '0;
            io_dly_q  <= '0;
        end
        else
        begin
            gclk_s1_q <= global_clock_pin_i;
            gclk_s2_q <= gclk_s1_q;
            io_s1_q   <= io_direct_i;
            io_s2_q   <= io_s1_q;
            io_dly_q  <= io_s2_q;  // extra stage buys zero hold at the cost of set-up
        end
    end

    // true and complement lines of every routing-pool input
    assign literal = {~global_routing_pool_i, global_routing_pool_i};

    // wired-AND per term; a term with no literal connected stays low
    for (genvar t = 0; t < NUM_TERMS; t++)
    begin : g_term
        logic [NUM_LITERALS-1:0] conn;
        assign conn    = and_conn_cfg_i[t*NUM_LITERALS +: NUM_LITERALS];
        assign term[t] = (|conn) & (&(literal | ~conn));
    end

    // shared control terms with optional inversion
    assign shared_term_clock          = term[SHARED_CLK_TERM] ^ shared_clk_inv_cfg_i;
    assign shared_term_initialization = term[SHARED_INIT_TERM] ^ shared_init_inv_cfg_i;

    // per-group OR over the terms left in logic use
    for (genvar g = 0; g < NUM_MACROCELLS; g++)
    begin : g_group
        logic [GROUP_SIZE-1:0] logic_terms;
        assign logic_terms = term[g*GROUP_SIZE +: GROUP_SIZE]
                           & ~term_ctl_cfg_i[g*GROUP_SIZE +: GROUP_SIZE];
        assign group_or[g] = |logic_terms;
    end

    // cluster steering: each group lands on one neighbour, groups past the edge vanish
    always_comb
    begin
        int dest;
        dest          = 0;
        cluster_local = '0;
        for (int g = 0; g < NUM_MACROCELLS; g++)
        begin
            dest = g + CLUSTER_DEST_BIAS - int'(group_dest_cfg_i[g*GROUP_SEL_W +: GROUP_SEL_W]);
            for (int m = 0; m < NUM_MACROCELLS; m++)
            begin
                if (m == dest)
                begin
                    cluster_local[m] = cluster_local[m] | group_or[g];
                end
            end
        end
    end

    // wide steering chains; two laps around the ring avoid a combinational loop
    for (genvar k = 0; k < NUM_CHAINS; k++)
    begin : g_chain
        logic [CHAIN_STAGES-1:0] link;
        logic [CHAIN_STAGES-1:0] eff;
        logic [CHAIN_STAGES-1:0] sum;
        for (genvar j = 0; j < CHAIN_STAGES; j++)
        begin : g_link
            assign link[j] = wide_steer_cfg_i[k + CHAIN_STRIDE*j];
        end
        // a fully closed ring is cut at its last stage so the chain has an end
        always_comb
        begin
            logic carry;
            logic acc;
            carry = 1'h0;
            acc   = 1'h0;
            eff   = link;
            if (&link)
            begin
                eff[CHAIN_STAGES-1] = 1'h0;
            end
            sum = '0;
            for (int i = 0; i < 2*CHAIN_STAGES; i++)
            begin
                acc = cluster_local[k + CHAIN_STRIDE*(i % CHAIN_STAGES)] | carry;
                if (i >= CHAIN_STAGES)
                begin
                    sum[i % CHAIN_STAGES] = acc;
                end
                carry = eff[i % CHAIN_STAGES] & acc;
            end
        end
        for (genvar j = 0; j < CHAIN_STAGES; j++)
        begin : g_out
            assign cluster_sum[k + CHAIN_STRIDE*j] = sum[j];
            assign wide_eff[k + CHAIN_STRIDE*j]    = eff[j];
        end
    end

    // a stage that forwards its sum leaves its own macrocell at zero
    assign mc_in = cluster_sum & ~wide_eff;

    // block clock generator: any pin, true or complement
    for (genvar b = 0; b < NUM_BLOCK_CLOCKS; b++)
    begin : g_bclk
        assign block_clock[b] = gclk_s2_q[block_clk_pin_cfg_i[b*GCLK_SEL_W +: GCLK_SEL_W]]
                              ^ block_clk_inv_cfg_i[b];
    end

    // power-up pending flag: lets each storage element with block init enabled load its set/reset state once, others load 0
    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            pwrup_q <= PWRUP_RST;
        end
        else
        begin
            pwrup_q <= 1'h0;
        end
    end

    // macrocells
    for (genvar m = 0; m < NUM_MACROCELLS; m++)
    begin : g_mc
        localparam int BASE = m * GROUP_SIZE;
        logic                 ctl_xor;
        logic                 individual_term_clock;
        logic                 init_ce_term;
        logic                 individual_term_initialization;
        logic                 xor_out;
        logic                 data_in;
        logic                 sel_clk;
        logic                 sel_ce;
        logic                 init_act;
        logic                 store_d;
        logic                 store_q;
        logic                 clk_prev_q;
        logic                 out_q;
        plb_clk_src_t         clk_src;
        plb_ce_src_t          ce_src;

        // control terms by their position in the group
        assign ctl_xor               = term[BASE+TERM_XOR_OFS] & term_ctl_cfg_i[BASE+TERM_XOR_OFS];
        assign individual_term_clock = term[BASE+TERM_CLK_OFS] & term_ctl_cfg_i[BASE+TERM_CLK_OFS];
        assign init_ce_term          = term[BASE+TERM_INIT_CE_OFS] & term_ctl_cfg_i[BASE+TERM_INIT_CE_OFS];
        assign individual_term_initialization = (term[BASE+TERM_INIT_OFS] & term_ctl_cfg_i[BASE+TERM_INIT_OFS])
                                              | (init_ce_term & ~init_ce_mode_cfg_i[m]);

        // programmable XOR, then choice of allocator or direct I/O input
        assign xor_out = mc_in[m] ^ ctl_xor ^ xor_pol_cfg_i[m];
        assign data_in = io_reg_cfg_i[m] ? (io_delay_cfg_i[m] ? io_dly_q[m] : io_s2_q[m])
                                         : xor_out;

        assign clk_src = plb_clk_src_t'(clk_sel_cfg_i[m*CLK_SEL_W +: CLK_SEL_W]);
        assign ce_src  = plb_ce_src_t'(ce_sel_cfg_i[m*CE_SEL_W +: CE_SEL_W]);

        // storage clock selector
        always_comb
        begin
            case (clk_src)
                CLK_BLOCK0:   sel_clk = block_clock[0];
                CLK_BLOCK1:   sel_clk = block_clock[1];
                CLK_BLOCK2:   sel_clk = block_clock[2];
                CLK_BLOCK3:   sel_clk = block_clock[3];
                CLK_TERM:     sel_clk = individual_term_clock;
                CLK_TERM_INV: sel_clk = ~individual_term_clock;
                CLK_SHARED:   sel_clk = shared_term_clock;
                CLK_GROUND:   sel_clk = 1'h0;
                default:      sel_clk = 1'h0;
            endcase
        end

        // clock enable selector
        always_comb
        begin
            case (ce_src)
                CE_TERM:       sel_ce = init_ce_term;
                CE_TERM_INV:   sel_ce = ~init_ce_term;
                CE_SHARED_CLK: sel_ce = shared_term_clock;
                CE_HIGH:       sel_ce = 1'h1;
                default:       sel_ce = 1'h1;
            endcase
        end

        // init wins over clocking; init_set picks preset or reset
        assign init_act = (block_init_en_cfg_i[m] & shared_term_initialization) | individual_term_initialization;

        // next storage value; clock edges are seen as core_clk samples, so a
        // selected clock must stay high and low for at least one core cycle each
        always_comb
        begin
            store_d = store_q;
            if (pwrup_q)
            begin
                store_d = init_set_cfg_i[m] & block_init_en_cfg_i[m];
            end
            else if (init_act)
            begin
                store_d = init_set_cfg_i[m];
            end
            else if (latch_mode_cfg_i[m])
            begin
                if (sel_clk && sel_ce)
                begin
                    store_d = data_in;
                end
            end
            else if (sel_clk && !clk_prev_q && sel_ce)
            begin
                store_d = data_in;
            end
        end

        // storage element and its output register
        always_ff @(posedge core_clk_i or posedge rst_i)
        begin
            if (rst_i)
            begin
                store_q    <= STORE_RST;
                clk_prev_q <= 1'h0;
                out_q      <= OUT_RST;
            end
            else
            begin
                store_q    <= store_d;
                clk_prev_q <= sel_clk;
                out_q      <= comb_out_cfg_i[m] ? xor_out : store_d;
            end
        end

        // same value to both pools; nothing loops back locally
        assign global_routing_pool_o[m] = out_q;
        assign output_routing_pool_o[m] = out_q;
    end

    // fast path and output enables, registered toward the I/O cells
    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            fast_q      <= '0;
            oe_q        <= '0;
            shared_oe_q <= OUT_RST;
        end
        else
        begin
            fast_q      <= group_or;
            shared_oe_q <= term[SHARED_OE_TERM];
            for (int m = 0; m < NUM_MACROCELLS; m++)
            begin
                oe_q[m] <= term[m*GROUP_SIZE+TERM_OE_OFS] & term_ctl_cfg_i[m*GROUP_SIZE+TERM_OE_OFS];
            end
        end
    end

    assign fast_path_o                     = fast_q;
    assign individual_term_output_enable_o = oe_q;
    assign shared_term_output_enable_o     = shared_oe_q;

    // configuration is read every cycle and must not move
    // while running; a change mid-run leaves storage
    // undefined

endmodule // plb_logic_block

// file: testbench/plb_logic_block_asserts.sv
// checker for plb_logic_block: outputs against terms and configuration
// assumes configuration changes only while rst_i is high
module plb_logic_block_asserts
    import plb_pkg::*;
#(
    parameter int NUM_BLOCKS  = PLB_MAX_BLOCKS,
    parameter int BLOCK_INDEX = 0
)
(
    input wire logic                                core_clk_i,
    input wire logic                                rst_i,
    input wire logic [NUM_INPUTS-1:0]               global_routing_pool_i,
    input wire logic [NUM_TERMS*NUM_LITERALS-1:0]   and_conn_cfg_i,
    input wire logic [NUM_LOGIC_TERMS-1:0]          term_ctl_cfg_i,
    input wire logic [NUM_MACROCELLS-1:0]           wide_steer_cfg_i,
    input wire logic [NUM_MACROCELLS-1:0]           xor_pol_cfg_i,
    input wire logic [NUM_MACROCELLS*CLK_SEL_W-1:0] clk_sel_cfg_i,
    input wire logic [NUM_MACROCELLS-1:0]           init_ce_mode_cfg_i,
    input wire logic [NUM_MACROCELLS-1:0]           block_init_en_cfg_i,
    input wire logic [NUM_MACROCELLS-1:0]           init_set_cfg_i,
    input wire logic [NUM_MACROCELLS-1:0]           comb_out_cfg_i,
    input wire logic [NUM_MACROCELLS-1:0]           global_routing_pool_o,
    input wire logic [NUM_MACROCELLS-1:0]           output_routing_pool_o,
    input wire logic [NUM_MACROCELLS-1:0]           fast_path_o,
    input wire logic [NUM_MACROCELLS-1:0]           individual_term_output_enable_o,
    input wire logic                                shared_term_output_enable_o
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [NUM_TERMS-1:0]      tv;
    logic [NUM_MACROCELLS-1:0] sum_v;
    logic [NUM_MACROCELLS-1:0] oe_v;
    logic [NUM_MACROCELLS-1:0] hold_v;
    logic [NUM_MACROCELLS-1:0] wz_v;

    // reference terms; an empty term reads 0
    always_comb
    begin
        logic [NUM_LITERALS-1:0] c;
        int                      b;
        c = '0;
        b = 0;
        for (int t = 0; t < NUM_TERMS; t++)
        begin
            c     = and_conn_cfg_i[t*NUM_LITERALS +: NUM_LITERALS];
            tv[t] = (|c) && (&(~c | {~global_routing_pool_i, global_routing_pool_i}));
        end
        for (int m = 0; m < NUM_MACROCELLS; m++)
        begin
            b         = m * GROUP_SIZE;
            sum_v[m]  = |(tv[b +: GROUP_SIZE] & ~term_ctl_cfg_i[b +: GROUP_SIZE]);
            oe_v[m]   = tv[b+TERM_OE_OFS] & term_ctl_cfg_i[b+TERM_OE_OFS];
            wz_v[m]   = wide_steer_cfg_i[m] & comb_out_cfg_i[m] & ~xor_pol_cfg_i[m] & ~term_ctl_cfg_i[b];
            hold_v[m] = (clk_sel_cfg_i[m*CLK_SEL_W +: CLK_SEL_W] == CLK_GROUND) & ~comb_out_cfg_i[m]
                      & ~block_init_en_cfg_i[m] & ~term_ctl_cfg_i[b+TERM_INIT_OFS]
                      & ~(term_ctl_cfg_i[b+TERM_INIT_CE_OFS] & ~init_ce_mode_cfg_i[m]);
        end
    end

    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (rst_i);

    AST_RESET_CLEAR:
        assert property ($fell(rst_i) |-> (global_routing_pool_o | fast_path_o) == '0)
        else $error("outputs not clear after reset");
    AST_POWER_UP:
        assert property ($past(rst_i, 2) && !$past(rst_i) |->
            ((global_routing_pool_o ^ (init_set_cfg_i & block_init_en_cfg_i)) & ~comb_out_cfg_i) == '0)
        else $error("power-up value wrong");
    AST_POOLS_SAME:
        assert property (global_routing_pool_o == output_routing_pool_o)
        else $error("pool outputs differ");
    AST_SHARED_OE:
        assert property (!$past(rst_i) |-> shared_term_output_enable_o == $past(tv[SHARED_OE_TERM]))
        else $error("shared enable wrong");
    AST_FAST_PATH:
        assert property (1'h1 |=> fast_path_o == $past(sum_v))
        else $error("fast path wrong");
    AST_TERM_OE:
        assert property (!$past(rst_i) |-> individual_term_output_enable_o == $past(oe_v))
        else $error("term enable wrong");
    AST_WIDE_ZERO:
        assert property (!$past(rst_i) |-> (global_routing_pool_o & wz_v) == '0)
        else $error("steered source not zero");
    AST_GND_HOLD:
        assert property (!$past(rst_i) && !$past(rst_i, 2) |->
            ((global_routing_pool_o ^ $past(global_routing_pool_o)) & hold_v) == '0)
        else $error("grounded clock cell changed");

    COV_SHARED_OE: cover property ($rose(shared_term_output_enable_o));
    COV_FAST:      cover property ($rose(|fast_path_o));
    COV_POWER_UP:  cover property ($fell(rst_i) ##1 |global_routing_pool_o);

endmodule // plb_logic_block_asserts

bind plb_logic_block plb_logic_block_asserts #(
    .NUM_BLOCKS(NUM_BLOCKS),
    .BLOCK_INDEX(BLOCK_INDEX)
) plb_logic_block_asserts_i (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .global_routing_pool_i(global_routing_pool_i),
    .and_conn_cfg_i(and_conn_cfg_i), .term_ctl_cfg_i(term_ctl_cfg_i), .wide_steer_cfg_i(wide_steer_cfg_i),
    .xor_pol_cfg_i(xor_pol_cfg_i), .clk_sel_cfg_i(clk_sel_cfg_i), .init_ce_mode_cfg_i(init_ce_mode_cfg_i),
    .block_init_en_cfg_i(block_init_en_cfg_i), .init_set_cfg_i(init_set_cfg_i), .comb_out_cfg_i(comb_out_cfg_i),
    .global_routing_pool_o(global_routing_pool_o), .output_routing_pool_o(output_routing_pool_o),
    .fast_path_o(fast_path_o), .individual_term_output_enable_o(individual_term_output_enable_o),
    .shared_term_output_enable_o(shared_term_output_enable_o)
);

// file: testbench/plb_pool_model.sv
// routing pool model: bench lines plus the block's returned outputs
// assumes the bench drives the external lines off the clock edge
module plb_pool_model
    import plb_pkg::*;
(
    input  wire logic [NUM_INPUTS-1:0]     ext_i,
    input  wire logic [NUM_MACROCELLS-1:0] mc_i,
    output logic      [NUM_INPUTS-1:0]     pool_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // own outputs come back through the pool, never a local path
    assign pool_o = {mc_i, ext_i[NUM_INPUTS-NUM_MACROCELLS-1:0]};

endmodule // plb_pool_model

// file: testbench/plb_logic_block_tb.sv
// self-checking bench for one logic block behind a routing pool model
// assumes one static configuration, loaded while reset is held
module plb_logic_block_tb
    import plb_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic                                 clk;
    logic                                 rst;
    logic [NUM_INPUTS-1:0]                ext;
    logic [NUM_INPUTS-1:0]                pool;
    logic [NUM_MACROCELLS-1:0]            io_pin;
    logic [NUM_GCLK-1:0]                  gclk_pin;
    logic [NUM_TERMS*NUM_LITERALS-1:0]    and_conn;
    logic [NUM_LOGIC_TERMS-1:0]           term_ctl;
    logic [NUM_MACROCELLS*GROUP_SEL_W-1:0] grp_dest;
    logic [NUM_MACROCELLS-1:0]            wide, xpol, ce_mode, init_en, init_set, latch, comb, io_reg, io_dly;
    logic [NUM_MACROCELLS*CLK_SEL_W-1:0]  clk_sel;
    logic [NUM_MACROCELLS*CE_SEL_W-1:0]   ce_sel;
    logic [NUM_BLOCK_CLOCKS*GCLK_SEL_W-1:0] bclk_pin;
    logic [NUM_BLOCK_CLOCKS-1:0]          bclk_inv;
    logic                                 sclk_inv, sinit_inv, shared_oe;
    logic [NUM_MACROCELLS-1:0]            grp_o, orp_o, fp_o, oe_o;
    int                                   n_mismatch, cmp_count;

    plb_pool_model plb_pool_model_i (.ext_i(ext), .mc_i(grp_o), .pool_o(pool));

    plb_logic_block #(.NUM_BLOCKS(2), .BLOCK_INDEX(0)) plb_logic_block_i (
        .core_clk_i(clk), .rst_i(rst), .global_routing_pool_i(pool), .io_direct_i(io_pin),
        .global_clock_pin_i(gclk_pin), .and_conn_cfg_i(and_conn), .term_ctl_cfg_i(term_ctl),
        .group_dest_cfg_i(grp_dest), .wide_steer_cfg_i(wide), .shared_clk_inv_cfg_i(sclk_inv),
        .shared_init_inv_cfg_i(sinit_inv), .xor_pol_cfg_i(xpol), .clk_sel_cfg_i(clk_sel), .ce_sel_cfg_i(ce_sel),
        .init_ce_mode_cfg_i(ce_mode), .block_init_en_cfg_i(init_en), .init_set_cfg_i(init_set),
        .latch_mode_cfg_i(latch), .comb_out_cfg_i(comb), .io_reg_cfg_i(io_reg), .io_delay_cfg_i(io_dly),
        .block_clk_pin_cfg_i(bclk_pin), .block_clk_inv_cfg_i(bclk_inv), .global_routing_pool_o(grp_o),
        .output_routing_pool_o(orp_o), .fast_path_o(fp_o), .individual_term_output_enable_o(oe_o),
        .shared_term_output_enable_o(shared_oe)
    );

    // 40 MHz core clock
    always #12.5 clk = ~clk;

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk(input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[ERR] %0t exp %h got %h", $time, exp, got);
        end
    endtask

    // bounded wait; running out ends the run
    task automatic wait_mc(input int m, input logic v);
        int k;
        k = 0;
        while (k < 16 && grp_o[m] !== v)
        begin
            tick(1);
            k++;
        end
        chk({15'h0, v}, {15'h0, grp_o[m]});
        if (grp_o[m] !== v)
            final_report();
    endtask

    task automatic link(input int t, input int l);
        and_conn[t*NUM_LITERALS+l] = 1'h1;
    endtask

    // shared enable term is in0 and not in1
    task automatic t_terms();
        for (int i = 0; i < 4; i++)
        begin
            ext[1:0] = i[1:0];
            tick(2);
            chk({15'h0, i == 1}, {15'h0, shared_oe});
        end
    endtask

    // group 2: term 10 logic, term 14 steered to the enable
    task automatic t_group();
        ext[7:6] = 2'h2;
        tick(2);
        chk(16'h0004, oe_o);
        chk(16'h0000, fp_o);
        ext[7:6] = 2'h1;
        tick(2);
        chk(16'h0000, oe_o);
        chk(16'h0004, fp_o);
    endtask

    // wide link 0 to 4, group 9 pulled into cell 8, cell 4 fed back
    task automatic t_steer();
        ext[3:2] = 2'h3;
        tick(2);
        chk(16'h1110, grp_o & 16'h1111);
        chk(16'h020D, fp_o);
    endtask

    // cell 1 stores on the inverted shared clock only
    task automatic t_clock();
        ext[5:4] = 2'h3;
        tick(4);
        chk(16'h0000, grp_o & 16'h0002);
        ext[4] = 1'h0;
        wait_mc(1, 1'h1);
        ext[5] = 1'h0;
        tick(4);
        chk(16'h0002, grp_o & 16'h0002);
    endtask

    // cell 2 registers its pin on block clock 0
    task automatic t_io();
        io_pin[2] = 1'h1;
        tick(6);
        chk(16'h0000, grp_o & 16'h0004);
        gclk_pin[0] = 1'h1;
        wait_mc(2, 1'h1);
    endtask

    // second reset in mid-run
    task automatic t_reset();
        rst = 1'h1;
        tick(3);
        chk(16'h0000, grp_o | fp_o | oe_o | {15'h0, shared_oe});
        rst = 1'h0;
        tick(2);
        chk(16'h1110, grp_o & 16'h1111);
        chk(16'h1110, orp_o & 16'h1111);
    endtask

    // static configuration, set under reset
    initial
    begin
        clk = 1'h0;
        rst = 1'h1;
        {ext, io_pin, gclk_pin, and_conn, term_ctl, bclk_pin, bclk_inv} = '0;
        {wide, xpol, ce_mode, latch, io_reg, sinit_inv, n_mismatch, cmp_count} = '0;
        grp_dest = {NUM_MACROCELLS{2'h1}};
        grp_dest[18 +: 2] = 2'h2;
        clk_sel = {NUM_MACROCELLS{3'h7}};
        clk_sel[3 +: 3] = CLK_SHARED;
        clk_sel[6 +: 3] = CLK_BLOCK0;
        ce_sel = {NUM_MACROCELLS{2'h3}};
        init_en = 16'h5000;
        init_set = 16'h3000;
        comb = 16'h0111;
        io_reg = 16'h0004;
        io_dly = 16'h0004;
        wide[0] = 1'h1;
        sclk_inv = 1'h1;
        term_ctl[14] = 1'h1;
        link(0, 2);
        link(5, 5);
        link(10, 6);
        link(14, 7);
        link(15, 24);
        link(45, 3);
        link(80, 4);
        link(82, 0);
        link(82, 37);
        tick(16);
        rst = 1'h0;
        tick(2);
        chk(16'h1000, grp_o);
        chk(16'h1000, orp_o);
        t_terms();
        t_group();
        t_steer();
        t_clock();
        t_io();
        t_reset();
        final_report();
    end

endmodule // plb_logic_block_tb
